//--- design/twb_pkg.sv
// Shared constants and types for the two-wire bus master controller
package twb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: system clock and fastest allowed bus clock
  localparam int CLK_NS = 40;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  // Quarter period is a least time, so it rounds up to whole cycles
  localparam int QTR_CYC_INT = (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] QTR_CYC = 5'(QTR_CYC_INT);

  ////////////////////////////////////////////////////////////////////////////
  // Packet layout: eight payload bits then one acknowledge bit
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;
  localparam logic [3:0] PKT_EDGES = 4'h9;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam logic [3:0] RSV_ADDR_HI = 4'hf;
  localparam logic RW_READ = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Phase codes within one bit, start or stop sequence
  localparam logic [1:0] PH_LOW = 2'h0;
  localparam logic [1:0] PH_DATA = 2'h1;
  localparam logic [1:0] PH_RISE = 2'h2;
  localparam logic [1:0] PH_HIGH = 2'h3;

  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_START = 4'h2,
    ST_BIT = 4'h4,
    ST_STOP = 4'h8
  } twb_state_t;

  // User commands
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2,
    OP_STOP = 2'h3
  } twb_op_t;

  // Whole state of the master
  typedef struct packed {
    twb_state_t st;
    logic [1:0] ph;
    logic [4:0] tmr;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic rd;
    logic ack_tx;
    logic scl_oe;
    logic sda_oe;
    logic own;
    logic data_seen;
    logic busy;
    logic scl_d;
    logic sda_d;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_nack;
    logic arb_lost;
    logic cmd_err;
  } twb_regs_t;

  localparam twb_regs_t REGS_RST = '{st: ST_IDLE, scl_d: 1'b1, sda_d: 1'b1,
                                     default: '0};

  // State of the two-stage input synchroniser
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } twb_sync_regs_t;

  localparam twb_sync_regs_t SYNC_RST = '{meta: 2'h3, sync: 2'h3};

endpackage

//--- design/twb_sync.sv
// Two-flop synchroniser for the bus clock and data lines
`timescale 1ns/1ps
`default_nettype none

module twb_sync (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Raw line levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Synchronised levels
  output logic scl_s,
  output logic sda_s
);

  twb_pkg::twb_sync_regs_t r_reg;
  twb_pkg::twb_sync_regs_t r_next;

  // First stage feeds only the second stage, never any logic
  always_comb begin
    r_next = r_reg;
    r_next.meta = {scl_in, sda_in};
    r_next.sync = r_reg.meta;
  end

  // Lines idle high, so reset to the released level
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= twb_pkg::SYNC_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign scl_s = r_reg.sync[1];
  assign sda_s = r_reg.sync[0];

endmodule

`default_nettype wire

//--- design/twb_master.sv
// Two-wire bus master: start, stop, byte transfer, acknowledge, arbitration
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: Each bit gets exactly one clock pulse; the master makes the pulse.
// R2: Data changes only while the clock is low, except start and stop.
// R3: Start and stop are data edges made while the clock is high.
// R4: Only the owning master starts or ends a transfer.
// R5: Bus is busy from a start until the next stop; no seizing it.
// R6: Repeated start keeps the bus; it stays busy until the next stop.
// R7: Address packet is nine clocks: seven address, direction, acknowledge.
// R8: Direction one means read, zero means write.
// R9: Addressed slave pulls data low in the ninth clock.
// R10: Busy or unwilling slave leaves data high for not-acknowledge.
// R11: After not-acknowledge the master sends stop or repeated start; this master does not refuse a write or read after one.
// R12: Address byte goes most significant bit first.
// R13: Address zero is the general call, not a slave address.
// R14: General call with write is acknowledged by enabled slaves.
// R15: Never send the general call address with a read bit.
// R16: Addresses 1111xxx are reserved and not to be used.
// R17: Lines are only pulled low or released; wired-AND level.
// R18: Device holds a programmable seven-bit address and general call; this master holds no own address and does not answer a general call.
// R19: Device may be master or slave and joins arbitration; this design is master only, with no slave mode.
// R20: Bus clock runs at most 400 kHz.
// R21: Data packet is eight bits, msb first, then receiver acknowledge.
// R22: Receiver not-acknowledges its last byte by leaving data high.
// R23: Never send a start directly followed by a stop.
// R24: A slave may hold the clock low; high time counts from the rise.
// R25: Line inputs are synchronised before edge detection.
module twb_master (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  output logic cmd_err,
  // Response port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack,
  output logic arb_lost,
  // Bus status
  output logic bus_busy,
  output logic bus_owned,
  // Clock line, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // Data line, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  twb_pkg::twb_regs_t r_reg;
  twb_pkg::twb_regs_t r_next;
  logic scl_s;
  logic sda_s;
  logic start_det;
  logic stop_det;
  logic cmd_take;
  logic refuse;
  logic tx_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Decide whether a command breaks the bus protocol
  function automatic logic cmd_refused(input logic [1:0] op,
                                       input logic [7:0] data,
                                       input logic busy,
                                       input logic own,
                                       input logic seen);
    logic bad;
    bad = 1'b0;
    if (op == twb_pkg::OP_START) begin
      bad = busy && !own; // R5
    end else if (op == twb_pkg::OP_STOP) begin
      bad = !own || !seen; // R4 R23
    end else if (!own) begin
      bad = 1'b1; // R4
    end else if (!seen) begin
      // First byte after a start is the address packet
      bad = (op == twb_pkg::OP_READ) ||
            (data[7:1] == twb_pkg::GEN_CALL_ADDR &&
             data[0] == twb_pkg::RW_READ) || // R13 R14 R15
            (data[7:4] == twb_pkg::RSV_ADDR_HI); // R16
    end
    return bad;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Line inputs pass two flops before anything looks at them
  twb_sync u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .scl_in(scl_i),
    .sda_in(sda_i),
    .scl_s(scl_s),
    .sda_s(sda_s)
  ); // R25

  // Start and stop seen on the bus, whoever made them
  assign start_det = r_reg.scl_d && scl_s && r_reg.sda_d && !sda_s; // R3
  assign stop_det = r_reg.scl_d && scl_s && !r_reg.sda_d && sda_s; // R3

  assign cmd_ready = (r_reg.st == twb_pkg::ST_IDLE);
  assign cmd_take = cmd_valid && cmd_ready;
  assign refuse = cmd_refused(cmd_op, cmd_data, r_reg.busy, r_reg.own,
                              r_reg.data_seen);

  // Level this master wants on data for the current bit
  always_comb begin
    if (r_reg.bitn != twb_pkg::ACK_BIT_IDX) begin
      tx_bit = r_reg.rd ? 1'b1 : r_reg.shreg[7]; // R12 R21
    end else begin
      tx_bit = r_reg.rd ? r_reg.ack_tx : 1'b1; // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole master
  always_comb begin
    r_next = r_reg;
    r_next.rsp_valid = 1'b0;
    r_next.arb_lost = 1'b0;
    r_next.cmd_err = 1'b0;
    r_next.scl_d = scl_s;
    r_next.sda_d = sda_s;
    // Busy tracking; a repeated start simply keeps it set
    if (start_det) begin
      r_next.busy = 1'b1; // R5 R6
    end else if (stop_det) begin
      r_next.busy = 1'b0; // R5
    end
    case (r_reg.st)
      twb_pkg::ST_IDLE: begin
        if (cmd_take && refuse) begin
          r_next.cmd_err = 1'b1;
        end else if (cmd_take) begin
          r_next.ph = twb_pkg::PH_LOW;
          r_next.tmr = twb_pkg::QTR_CYC;
          case (cmd_op)
            twb_pkg::OP_START: begin
              // Release data first; the clock is still held if owned
              r_next.st = twb_pkg::ST_START; // R4 R6 R11
              r_next.sda_oe = 1'b0;
            end
            twb_pkg::OP_STOP: begin
              // Clock is low here, so pulling data low is legal
              r_next.st = twb_pkg::ST_STOP; // R4 R11
              r_next.sda_oe = 1'b1;
            end
            default: begin
              r_next.st = twb_pkg::ST_BIT;
              r_next.bitn = '0;
              r_next.rd = (cmd_op == twb_pkg::OP_READ); // R8
              r_next.shreg = cmd_data; // R18
              r_next.ack_tx = cmd_nack;
            end
          endcase
        end
      end
      default: begin
        if (r_reg.ph == twb_pkg::PH_RISE && !scl_s) begin
          // Clock held low by a slave: high time starts at the rise
          r_next.tmr = twb_pkg::QTR_CYC; // R24
        end else if (r_reg.tmr != '0) begin
          r_next.tmr = r_reg.tmr - 5'h01; // R20
        end else begin
          r_next.tmr = twb_pkg::QTR_CYC;
          r_next.ph = r_reg.ph + 2'h1;
          case (r_reg.ph)
            twb_pkg::PH_LOW: begin
              // Data moves only in the low half of the clock
              if (r_reg.st == twb_pkg::ST_BIT) begin
                r_next.sda_oe = !tx_bit; // R2 R17
              end
            end
            twb_pkg::PH_DATA: begin
              r_next.scl_oe = 1'b0; // R1 R17
            end
            twb_pkg::PH_RISE: begin
              if (r_reg.st == twb_pkg::ST_START) begin
                r_next.sda_oe = 1'b1; // R3
              end else if (r_reg.st == twb_pkg::ST_STOP) begin
                r_next.sda_oe = 1'b0; // R3
              end else if (r_reg.bitn == twb_pkg::ACK_BIT_IDX) begin
                r_next.rsp_nack = sda_s; // R9 R10
              end else if (!r_reg.rd && !r_reg.sda_oe && !sda_s) begin
                // Released a one but saw a zero: another master won
                r_next.st = twb_pkg::ST_IDLE; // R19
                r_next.scl_oe = 1'b0;
                r_next.sda_oe = 1'b0;
                r_next.own = 1'b0;
                r_next.arb_lost = 1'b1;
              end else begin
                r_next.shreg = {r_reg.shreg[6:0], sda_s}; // R12 R21
              end
            end
            default: begin
              if (r_reg.st == twb_pkg::ST_STOP) begin
                r_next.st = twb_pkg::ST_IDLE;
                r_next.own = 1'b0; // R4
              end else begin
                // Hold the clock low so the bus stays ours
                r_next.scl_oe = 1'b1;
                if (r_reg.st == twb_pkg::ST_START) begin
                  r_next.st = twb_pkg::ST_IDLE;
                  r_next.own = 1'b1;
                  r_next.data_seen = 1'b0;
                end else if (r_reg.bitn == twb_pkg::ACK_BIT_IDX) begin
                  r_next.st = twb_pkg::ST_IDLE; // R7 R21
                  r_next.rsp_valid = 1'b1;
                  r_next.rsp_data = r_reg.shreg;
                  r_next.data_seen = 1'b1;
                end else begin
                  r_next.bitn = r_reg.bitn + 4'h1;
                end
              end
            end
          endcase
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= twb_pkg::REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; the drivers only ever pull low
  assign scl_o = 1'b0; // R17
  assign sda_o = 1'b0; // R17
  assign scl_oe = r_reg.scl_oe;
  assign sda_oe = r_reg.sda_oe;
  assign bus_busy = r_reg.busy;
  assign bus_owned = r_reg.own;
  assign rsp_valid = r_reg.rsp_valid;
  assign rsp_data = r_reg.rsp_data;
  assign rsp_nack = r_reg.rsp_nack;
  assign arb_lost = r_reg.arb_lost;
  assign cmd_err = r_reg.cmd_err;

  ////////////////////////////////////////////////////////////////////////////
  // Helper: clock rises seen during one byte, for the checks below
  logic [3:0] rise_cnt;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rise_cnt <= '0;
    end else if (cmd_take) begin
      rise_cnt <= '0;
    end else if (scl_s && !r_reg.scl_d && r_reg.st == twb_pkg::ST_BIT) begin
      rise_cnt <= rise_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  nine_clocks_a: assert property ( // R7
    rsp_valid |-> rise_cnt == twb_pkg::PKT_EDGES)
    else $error("byte did not take nine clock pulses");

  data_stable_a: assert property ( // R2
    (r_reg.st == twb_pkg::ST_BIT && scl_s && r_reg.scl_d)
      |-> $stable(sda_oe))
    else $error("data moved while clock high");

  busy_set_a: assert property ( // R5
    start_det |=> bus_busy)
    else $error("bus not busy after start");

  busy_clr_a: assert property ( // R5
    stop_det && !start_det |=> !bus_busy)
    else $error("bus still busy after stop");

  seize_refused_a: assert property ( // R5
    cmd_take && cmd_op == twb_pkg::OP_START && bus_busy && !bus_owned
      |=> cmd_err && $stable(scl_oe))
    else $error("start taken on a foreign busy bus");

  empty_msg_a: assert property ( // R23
    cmd_take && cmd_op == twb_pkg::OP_STOP && !r_reg.data_seen
      |=> cmd_err ##1 r_reg.st == twb_pkg::ST_IDLE)
    else $error("stop right after start was not refused");

  gc_read_a: assert property ( // R15
    cmd_take && cmd_op == twb_pkg::OP_WRITE && !r_reg.data_seen &&
      cmd_data == 8'h01 |=> cmd_err)
    else $error("general call read was not refused");

  msb_first_a: assert property ( // R12
    r_reg.st == twb_pkg::ST_BIT && !r_reg.rd && r_reg.bitn == 4'h0 &&
      r_reg.ph == twb_pkg::PH_RISE |-> sda_oe == !r_reg.shreg[7])
    else $error("first bit out is not the msb");

  stretch_wait_a: assert property ( // R24
    r_reg.ph == twb_pkg::PH_RISE && r_reg.st != twb_pkg::ST_IDLE && !scl_s
      |=> r_reg.ph == twb_pkg::PH_RISE)
    else $error("high time counted while clock held low");

  arb_release_a: assert property ( // R19
    arb_lost |-> !sda_oe && !scl_oe && !bus_owned)
    else $error("lines still driven after lost arbitration");

  last_nack_a: assert property ( // R22
    r_reg.st == twb_pkg::ST_BIT && r_reg.rd && r_reg.ack_tx &&
      r_reg.bitn == twb_pkg::ACK_BIT_IDX && r_reg.ph == twb_pkg::PH_HIGH
      |-> !sda_oe)
    else $error("data held low for a not-acknowledge");

  start_edge_a: assert property ( // R3
    r_reg.st == twb_pkg::ST_START && r_reg.ph == twb_pkg::PH_RISE &&
      r_reg.tmr == '0 && scl_s |=> sda_oe && !scl_oe)
    else $error("start not made as a data fall under a high clock");

  stop_edge_a: assert property ( // R3
    r_reg.st == twb_pkg::ST_STOP && r_reg.ph == twb_pkg::PH_RISE &&
      r_reg.tmr == '0 && scl_s |=> !sda_oe && !scl_oe)
    else $error("stop not made as a data rise under a high clock");

  gc_write_ok_a: assert property ( // R14
    cmd_take && cmd_op == twb_pkg::OP_WRITE && bus_owned &&
      !r_reg.data_seen && cmd_data == 8'h00
      |=> !cmd_err && r_reg.st == twb_pkg::ST_BIT)
    else $error("general call write was refused");

  idle_release_a: assert property ( // R4
    r_reg.st == twb_pkg::ST_IDLE && !bus_owned |-> !scl_oe && !sda_oe)
    else $error("lines driven while idle and not owning the bus");

endmodule

`default_nettype wire

//--- testbench/twb_slave_model.sv
// Behavioural slave on the two-wire bus: address match, ack, read data
`timescale 1ns/1ps
`default_nettype none

module twb_slave_model #(
  parameter logic [6:0] OWN_ADDR = 7'h2a,
  parameter logic [7:0] RD_BYTE = 8'ha5
) (
  // Resolved lines
  input wire logic scl,
  input wire logic sda,
  // Scenario control
  input wire logic stretch,
  // Open-drain pulls, high = line held low
  output logic scl_pull,
  output logic sda_pull,
  // Last byte written to this slave
  output logic [7:0] last_byte
);
  int bitc;
  logic active, first, addressed, rd;
  logic [7:0] sh;

  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    active = 1'b0;
    last_byte = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop are data edges while the clock is high
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b1;
      bitc = 0;
      first = 1'b1;
      addressed = 1'b0;
      rd = 1'b0;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      active = 1'b0;
    end
  end

  // Sample on the rising clock; data only read while it is stable
  always @(posedge scl) begin
    if (active) begin
      if (bitc < 8) begin
        sh = {sh[6:0], sda};
      end
      bitc++;
      // Master not-acknowledge ends our read burst
      if (bitc == 9 && rd && !first && sda === 1'b1) begin
        addressed = 1'b0;
      end
    end
  end

  // Drive only while the clock is low
  always @(negedge scl) begin
    if (active) begin
      sda_pull = 1'b0;
      if (bitc == 8 && first) begin
        rd = sh[0];
        // General call only with a write bit
        addressed = (sh[7:1] == OWN_ADDR) || (sh == 8'h00);
        sda_pull = addressed;
      end else if (bitc == 8 && addressed && !rd) begin
        last_byte = sh;
        sda_pull = 1'b1;
      end else if (bitc == 9) begin
        bitc = 0;
        first = 1'b0;
      end
      if (addressed && rd && bitc < 8 && !first) begin
        sda_pull = ~RD_BYTE[7 - bitc];
      end
    end
  end

  // Clock stretching holds the low phase longer
  always @(negedge scl) begin
    if (stretch) begin
      scl_pull = 1'b1;
      #2000;
      scl_pull = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/two_wire_bus_framing_test.sv
// Self-checking bench for the two-wire bus master
`timescale 1ns/1ps
`default_nettype none

module two_wire_bus_framing_test;
  localparam logic [6:0] ADDR = 7'h2a;
  logic core_clk, arst_n, cmd_valid, cmd_nack, stretch, e, lost, ext_sda;
  logic [1:0] cmd_op;
  logic [7:0] cmd_data, last_byte;
  wire logic cmd_ready, cmd_err, rsp_valid, rsp_nack, arb_lost;
  wire logic bus_busy, bus_owned, scl_o, scl_oe, sda_o, sda_oe;
  wire logic [7:0] rsp_data;
  wire logic s_scl, s_sda, scl, sda;
  int fails, n_checks, n_edges, n0;

  // Wired-AND lines with pull-ups
  assign scl = ~(scl_oe | s_scl);
  // A second master is modelled by the bench pulling data low
  assign sda = ~(sda_oe | s_sda | ext_sda);

  twb_master DUT (.core_clk(core_clk), .arst_n(arst_n),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_err(cmd_err),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack),
    .arb_lost(arb_lost), .bus_busy(bus_busy), .bus_owned(bus_owned),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));

  twb_slave_model #(.OWN_ADDR(ADDR)) slave (.scl(scl), .sda(sda),
    .stretch(stretch), .scl_pull(s_scl), .sda_pull(s_sda),
    .last_byte(last_byte));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and rising-edge count of the bus clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge scl) n_edges++;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One command; waits bounded for the byte, the sequence or a refusal
  task automatic cmd(input logic [1:0] op, input logic [7:0] d,
                     input logic nk);
    int i;
    e = 1'b0;
    lost = 1'b0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1) @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    for (i = 0; i < 4000; i++) begin
      if (cmd_err === 1'b1) e = 1'b1;
      if (arb_lost === 1'b1) lost = 1'b1;
      if (rsp_valid === 1'b1 || (cmd_ready === 1'b1 && i > 2)) break;
      @(negedge core_clk);
    end
    if (i == 4000) check(8'h00, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_write();
    cmd(twb_pkg::OP_START, 8'h00, 1'b0);
    check({6'h0, bus_busy, bus_owned}, 8'h03);
    n0 = n_edges;
    cmd(twb_pkg::OP_WRITE, {ADDR, 1'b0}, 1'b0);
    check(n_edges - n0, 9);
    check({7'h0, rsp_nack}, 8'h00);
    cmd(twb_pkg::OP_WRITE, 8'h3c, 1'b0);
    check(last_byte, 8'h3c);
    cmd(twb_pkg::OP_STOP, 8'h00, 1'b0);
    check({6'h0, bus_busy, bus_owned}, 8'h00);
    check({6'h0, scl, sda}, 8'h03);
    check({6'h0, scl_o, sda_o}, 8'h00);
  endtask

  task automatic t_nack_restart_read();
    cmd(twb_pkg::OP_START, 8'h00, 1'b0);
    cmd(twb_pkg::OP_WRITE, {7'h11, 1'b0}, 1'b0);
    check({7'h0, rsp_nack}, 8'h01);
    cmd(twb_pkg::OP_START, 8'h00, 1'b0);
    check({7'h0, e}, 8'h00);
    check({6'h0, bus_busy, bus_owned}, 8'h03);
    cmd(twb_pkg::OP_WRITE, {ADDR, 1'b1}, 1'b0);
    check({7'h0, rsp_nack}, 8'h00);
    cmd(twb_pkg::OP_READ, 8'h00, 1'b0);
    check(rsp_data, 8'ha5);
    check({7'h0, rsp_nack}, 8'h00);
    cmd(twb_pkg::OP_READ, 8'h00, 1'b1);
    check(rsp_data, 8'ha5);
    check({7'h0, rsp_nack}, 8'h01);
    cmd(twb_pkg::OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic t_general_call();
    cmd(twb_pkg::OP_START, 8'h00, 1'b0);
    cmd(twb_pkg::OP_WRITE, 8'h00, 1'b0);
    check({7'h0, rsp_nack}, 8'h00);
    cmd(twb_pkg::OP_WRITE, 8'h77, 1'b0);
    check(last_byte, 8'h77);
    cmd(twb_pkg::OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic t_refusals();
    cmd(twb_pkg::OP_WRITE, {ADDR, 1'b0}, 1'b0);
    check({7'h0, e}, 8'h01);
    cmd(twb_pkg::OP_START, 8'h00, 1'b0);
    cmd(twb_pkg::OP_WRITE, 8'h01, 1'b0);
    check({7'h0, e}, 8'h01);
    cmd(twb_pkg::OP_WRITE, 8'hf4, 1'b0);
    check({7'h0, e}, 8'h01);
    cmd(twb_pkg::OP_READ, 8'h00, 1'b0);
    check({7'h0, e}, 8'h01);
    cmd(twb_pkg::OP_STOP, 8'h00, 1'b0);
    check({7'h0, e}, 8'h01);
    cmd(twb_pkg::OP_WRITE, {ADDR, 1'b0}, 1'b0);
    check({7'h0, e}, 8'h00);
    cmd(twb_pkg::OP_STOP, 8'h00, 1'b0);
    check({7'h0, bus_busy}, 8'h00);
  endtask

  // Other master holds data low; ours loses on its first released bit
  task automatic t_arbitration();
    cmd(twb_pkg::OP_START, 8'h00, 1'b0);
    ext_sda = 1'b1;
    cmd(twb_pkg::OP_WRITE, {ADDR, 1'b0}, 1'b0);
    check({7'h0, lost}, 8'h01);
    check({6'h0, bus_busy, bus_owned}, 8'h02);
    check({6'h0, scl_oe, sda_oe}, 8'h00);
    cmd(twb_pkg::OP_START, 8'h00, 1'b0);
    check({7'h0, e}, 8'h01);
    ext_sda = 1'b0;
    repeat (6) @(negedge core_clk);
    check({7'h0, bus_busy}, 8'h00);
  endtask

  task automatic t_stretch();
    @(negedge core_clk);
    stretch = 1'b1;
    cmd(twb_pkg::OP_START, 8'h00, 1'b0);
    n0 = n_edges;
    cmd(twb_pkg::OP_WRITE, {ADDR, 1'b0}, 1'b0);
    check(n_edges - n0, 9);
    check({7'h0, rsp_nack}, 8'h00);
    cmd(twb_pkg::OP_STOP, 8'h00, 1'b0);
    @(negedge core_clk);
    stretch = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    stretch = 1'b0;
    ext_sda = 1'b0;
    fails = 0;
    n_checks = 0;
    n_edges = 0;
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    check({6'h0, bus_busy, bus_owned}, 8'h00);
    t_write();
    t_nack_restart_read();
    t_general_call();
    t_refusals();
    t_arbitration();
    t_stretch();
    test_done();
  end

  // Run needs about 8k cycles; 30k cycles leaves ample margin
  initial begin
    #1200000;
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
